/* hw/msq_regs_pkg.sv */
package msq_regs_pkg;
    // A bus source select codes
    localparam logic [3:0] A_SCR0 = 4'h0;
    localparam logic [3:0] A_SCR1 = 4'h1;
    localparam logic [3:0] A_SCR2 = 4'h2;
    localparam logic [3:0] A_SCR3 = 4'h3;
    localparam logic [3:0] A_GEN0 = 4'h4;
    localparam logic [3:0] A_GEN1 = 4'h5;
    localparam logic [3:0] A_GEN2 = 4'h6;
    localparam logic [3:0] A_GEN3 = 4'h7;
    localparam logic [3:0] A_GEN4 = 4'h8;
    localparam logic [3:0] A_GEN5 = 4'h9;
    localparam logic [3:0] A_GEN6 = 4'hA;
    localparam logic [3:0] A_GEN7 = 4'hB;
    localparam logic [3:0] A_INTS = 4'hC;
    localparam logic [3:0] A_CNT = 4'hD;
    localparam logic [3:0] A_PAGE = 4'hE;
    localparam logic [3:0] A_CHK = 4'hF;
    // D bus destination codes (B bus reads use A_GEN0..A_GEN3)
    localparam logic [4:0] D_NONE = 5'h00;
    localparam logic [4:0] D_SCR0 = 5'h01;
    localparam logic [4:0] D_GEN0 = 5'h05;
    localparam logic [4:0] D_GEN4 = 5'h09;
    localparam logic [4:0] D_MASK = 5'h0D;
    localparam logic [4:0] D_CNT = 5'h0E;
    localparam logic [4:0] D_PAGE = 5'h0F;
    localparam logic [4:0] D_MCM = 5'h10;
    // T bus transfer codes
    localparam logic [3:0] T_NONE = 4'h0;
    localparam logic [3:0] T_SCR_FROM_T = 4'h1;
    localparam logic [3:0] T_SCR_TO_T = 4'h2;
    localparam logic [3:0] T_SCRHI_FROM_T = 4'h3;
    localparam logic [3:0] T_GEN_FROM_SCR = 4'h4;
    localparam logic [3:0] T_SCR_FROM_GEN = 4'h5;
    localparam logic [3:0] T_GEN_TO_T = 4'h6;
    localparam logic [3:0] T_GEN_FROM_T = 4'h7;
    localparam logic [3:0] T_GENLO_FROM_T = 4'h8;
    localparam logic [3:0] T_RET_FROM_SCR = 4'h9;
    localparam logic [3:0] T_SCR_FROM_RET = 4'hA;
    localparam logic [3:0] T_CNT_FROM_T = 4'hB;
    localparam logic [3:0] T_PAGE_FROM_T = 4'hC;
    // interrupt status bit positions
    localparam int INT_CHBYTE = 0;
    localparam int INT_XFER = 1;
    localparam int INT_SELCH = 2;
    localparam int INT_WRAP = 3;
    localparam int INT_INDEX = 4;
    localparam int INT_CHAN = 5;
    localparam int INT_RESP = 6;
    localparam int INT_CHK2 = 7;
    // check mux control fields
    localparam int MCM_ENCK = 0;
    localparam int MCM_CCKSEL = 4;
    localparam logic [2:0] MCM_GRP_BUFUNC = 3'h1;
    localparam logic [2:0] MCM_GRP_BUFCOR = 3'h3;
    localparam int CHK_LATCHES = 47;
    localparam int CHK_GROUPS = 6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int ADDR_W = 13;

    typedef struct packed {
        logic [3:0] aSel;
        logic [3:0] bSel;
        logic [4:0] dSel;
        logic [3:0] tSel;
        logic [7:0] dBus;
        logic [31:0] tBusIn;
        logic clearIndex;
        logic clearChecks;
        logic saveReturn;
        logic returnJump;
    } uop_type;

    typedef struct packed {
        logic chByteDone;
        logic chCounterLoad;
        logic xferDecToZero;
        logic xferLoad;
        logic opIn;
        logic selChOption;
        logic selectionLatch;
        logic addressOut;
        logic selectOut;
        logic truncation;
        logic indexAlert;
        logic tagAccepted;
        logic okEnd;
        logic errEnd;
        logic checkTwoSet;
        logic bufCorrectable;
        logic bufUncorrectable;
    } events_type;
endpackage

/* hw/microsequencer_register_set.sv */
`timescale 1ns/1ns
`default_nettype none
module microsequencer_register_set (
    input wire logic clk,
    input wire logic rst_n,
    input wire msq_regs_pkg::uop_type uop,
    input wire msq_regs_pkg::events_type evt,
    input wire logic [msq_regs_pkg::ADDR_W-1:0] curAddr,
    input wire logic [7:0] channelCheck,
    input wire logic [msq_regs_pkg::CHK_LATCHES-1:0] faultSet,
    output logic [7:0] aBus,
    output logic [7:0] bBus,
    output logic [31:0] tBusOut,
    output logic [7:0] branchSourceBus,
    output logic [7:0] branchHold,
    output logic maskedIntBranch,
    output logic counterWrapBranch,
    output logic [msq_regs_pkg::ADDR_W-1:0] returnAddress,
    output logic returnJumpTaken,
    output logic enableCheck,
    output logic [1:0] errorCapturePages,
    output logic [7:0] interruptStatus
);
    logic [31:0] scratchWordFile [16];
    logic [7:0] generalByteQuad [4];
    logic [7:0] generalByteFive, generalByteSix, generalByteSeven, generalByteEight;
    logic [7:0] pageSelectReg, interruptMaskReg, cycleCounterReg, checkMuxControl;
    logic counterCarry;
    logic [msq_regs_pkg::CHK_LATCHES-1:0] machineCheckLatches;
    logic checkTwoLatch, opInPrev;
    logic [31:0] curWord;
    logic [7:0] checkViewMux, checkGroup;
    logic [3:0] page;
    logic cntLoad;

    // lane 0 of the word is the most significant byte in the documented numbering
    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] lane);
        pick = w[8*(3-lane) +: 8];
    endfunction

    assign page = pageSelectReg[7:4];
    assign curWord = scratchWordFile[page];
    assign cntLoad = uop.dSel == msq_regs_pkg::D_CNT || uop.tSel == msq_regs_pkg::T_CNT_FROM_T;
    assign enableCheck = checkMuxControl[7 - msq_regs_pkg::MCM_ENCK];
    assign errorCapturePages = checkMuxControl[5:4];

    // 47 latches fill six groups of eight; the 48th slot reads zero
    always_comb begin
        logic [47:0] padded;
        logic [2:0] grp;
        padded = {1'b0, machineCheckLatches};
        grp = checkMuxControl[2:0];
        checkGroup = 8'h00;
        if (grp < 3'(msq_regs_pkg::CHK_GROUPS)) begin
            // latch 8g+k shows as documented bit k of the group, i.e. bus index 7-k
            for (int i = 0; i < 8; i++) begin
                checkGroup[7 - i] = padded[8 * grp + i];
            end
        end
    end

    // mux bit 4 is field bit 3 in LSB-first storage
    assign checkViewMux = checkMuxControl[7 - msq_regs_pkg::MCM_CCKSEL] ? channelCheck
                                                                        : checkGroup;

    always_comb begin
        case (uop.aSel)
            msq_regs_pkg::A_SCR0, msq_regs_pkg::A_SCR1,
            msq_regs_pkg::A_SCR2, msq_regs_pkg::A_SCR3:
                aBus = pick(curWord, uop.aSel[1:0]);
            msq_regs_pkg::A_GEN0, msq_regs_pkg::A_GEN1,
            msq_regs_pkg::A_GEN2, msq_regs_pkg::A_GEN3:
                aBus = generalByteQuad[uop.aSel[1:0]];
            msq_regs_pkg::A_GEN4: aBus = generalByteFive;
            msq_regs_pkg::A_GEN5: aBus = generalByteSix;
            msq_regs_pkg::A_GEN6: aBus = generalByteSeven;
            msq_regs_pkg::A_GEN7: aBus = generalByteEight;
            msq_regs_pkg::A_INTS: aBus = interruptStatus;
            msq_regs_pkg::A_CNT: aBus = cycleCounterReg;
            msq_regs_pkg::A_PAGE: aBus = pageSelectReg;
            msq_regs_pkg::A_CHK: aBus = checkViewMux;
            default: aBus = 8'h00;
        endcase
    end

    always_comb begin
        bBus = 8'h00;
        if (uop.bSel[3:2] == 2'b01) begin
            bBus = generalByteQuad[uop.bSel[1:0]];
        end
    end

    // branch bus: only byte five, eight, scratch bytes and status are wired
    always_comb begin
        case (pageSelectReg[3:0])
            4'h0: branchSourceBus = generalByteFive;
            4'h1: branchSourceBus = pick(curWord, 2'd1);
            4'h2: branchSourceBus = pick(curWord, 2'd2);
            4'h3: branchSourceBus = pick(curWord, 2'd3);
            4'h4: branchSourceBus = interruptStatus;
            4'h5: branchSourceBus = pick(curWord, 2'd0);
            4'h6: branchSourceBus = generalByteEight;
            default: branchSourceBus = 8'h00;
        endcase
    end

    always_comb begin
        case (uop.tSel)
            msq_regs_pkg::T_SCR_TO_T: tBusOut = curWord;
            msq_regs_pkg::T_GEN_TO_T: tBusOut = {generalByteQuad[0], generalByteQuad[1],
                                                 generalByteQuad[2], generalByteQuad[3]};
            default: tBusOut = 32'h0000_0000;
        endcase
    end

    assign maskedIntBranch = |(interruptStatus & interruptMaskReg);
    assign counterWrapBranch = counterCarry;
    assign returnJumpTaken = uop.returnJump;

    // scratch file; bits 23:16 are never loaded from the T bus, bits 15:8 only by T_SCRHI_FROM_T
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                scratchWordFile[i] <= 32'h0000_0000;
            end
        end else begin
            if (uop.dSel >= msq_regs_pkg::D_SCR0 && uop.dSel < msq_regs_pkg::D_SCR0 + 5'h04) begin
                scratchWordFile[page][8*(3-2'(uop.dSel - msq_regs_pkg::D_SCR0)) +: 8]
                    <= uop.dBus;
            end
            case (uop.tSel)
                msq_regs_pkg::T_SCR_FROM_T: begin
                    scratchWordFile[page][31:24] <= uop.tBusIn[31:24];
                    scratchWordFile[page][7:0] <= uop.tBusIn[7:0];
                end
                msq_regs_pkg::T_SCRHI_FROM_T: scratchWordFile[page][15:0] <= uop.tBusIn[15:0];
                msq_regs_pkg::T_SCR_FROM_GEN: scratchWordFile[page] <= {generalByteQuad[0],
                    generalByteQuad[1], generalByteQuad[2], generalByteQuad[3]};
                msq_regs_pkg::T_SCR_FROM_RET: scratchWordFile[page][15:0] <=
                    16'(returnAddress);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                generalByteQuad[i] <= msq_regs_pkg::RESET_BYTE;
            end
            generalByteFive <= msq_regs_pkg::RESET_BYTE;
            generalByteSix <= msq_regs_pkg::RESET_BYTE;
            generalByteSeven <= msq_regs_pkg::RESET_BYTE;
            generalByteEight <= msq_regs_pkg::RESET_BYTE;
        end else begin
            case (uop.dSel)
                5'h05, 5'h06, 5'h07, 5'h08: generalByteQuad[2'(uop.dSel - msq_regs_pkg::D_GEN0)]
                    <= uop.dBus;
                5'h09: generalByteFive <= uop.dBus;
                5'h0A: generalByteSix <= uop.dBus;
                5'h0B: generalByteSeven <= uop.dBus;
                5'h0C: generalByteEight <= uop.dBus;
                default: ;
            endcase
            case (uop.tSel)
                msq_regs_pkg::T_GEN_FROM_SCR: begin
                    for (int i = 0; i < 4; i++) begin
                        generalByteQuad[i] <= pick(curWord, 2'(i));
                    end
                end
                msq_regs_pkg::T_GEN_FROM_T: begin
                    for (int i = 0; i < 4; i++) begin
                        generalByteQuad[i] <= pick(uop.tBusIn, 2'(i));
                    end
                end
                msq_regs_pkg::T_GENLO_FROM_T: begin
                    generalByteQuad[2] <= uop.tBusIn[15:8];
                    generalByteQuad[3] <= uop.tBusIn[7:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pageSelectReg <= msq_regs_pkg::RESET_BYTE;
            interruptMaskReg <= msq_regs_pkg::RESET_BYTE;
            checkMuxControl <= msq_regs_pkg::RESET_BYTE;
            branchHold <= msq_regs_pkg::RESET_BYTE;
        end else begin
            branchHold <= branchSourceBus;
            if (uop.dSel == msq_regs_pkg::D_PAGE) begin
                pageSelectReg <= uop.dBus;
            end else if (uop.tSel == msq_regs_pkg::T_PAGE_FROM_T) begin
                pageSelectReg <= uop.tBusIn[7:0];
            end
            if (uop.dSel == msq_regs_pkg::D_MASK) begin
                interruptMaskReg <= uop.dBus;
            end
            if (uop.dSel == msq_regs_pkg::D_MCM) begin
                checkMuxControl <= uop.dBus;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycleCounterReg <= msq_regs_pkg::RESET_BYTE;
            counterCarry <= 1'b0;
        end else if (uop.dSel == msq_regs_pkg::D_CNT) begin
            cycleCounterReg <= uop.dBus;
            counterCarry <= 1'b0;
        end else if (cntLoad) begin
            cycleCounterReg <= uop.tBusIn[7:0];
            counterCarry <= 1'b0;
        end else begin
            cycleCounterReg <= cycleCounterReg + 8'h01;
            if (&cycleCounterReg) begin
                counterCarry <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            returnAddress <= '0;
        end else if (uop.saveReturn) begin
            returnAddress <= curAddr + 13'h0001;
        end else if (uop.tSel == msq_regs_pkg::T_RET_FROM_SCR) begin
            returnAddress <= curWord[msq_regs_pkg::ADDR_W-1:0];
        end
    end

    // check latches: any new fault wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            machineCheckLatches <= '0;
            checkTwoLatch <= 1'b0;
        end else begin
            machineCheckLatches <= (uop.clearChecks ? '0 : machineCheckLatches) | faultSet
                | (47'(evt.bufUncorrectable) << (8 * msq_regs_pkg::MCM_GRP_BUFUNC + 5))
                | (47'(evt.bufCorrectable) << (8 * msq_regs_pkg::MCM_GRP_BUFCOR + 1));
            checkTwoLatch <= (checkTwoLatch & ~uop.clearChecks) | evt.checkTwoSet
                | evt.bufCorrectable;
        end
    end

    // status kept in LSB-first storage so bit n of the doc is interruptStatus[7-n]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interruptStatus <= msq_regs_pkg::RESET_BYTE;
            opInPrev <= 1'b0;
        end else begin
            opInPrev <= evt.opIn;
            if (evt.chByteDone) begin
                interruptStatus[7 - msq_regs_pkg::INT_CHBYTE] <= 1'b1;
            end else if (evt.chCounterLoad) begin
                interruptStatus[7 - msq_regs_pkg::INT_CHBYTE] <= 1'b0;
            end
            if (evt.xferDecToZero) begin
                interruptStatus[7 - msq_regs_pkg::INT_XFER] <= 1'b1;
            end else if (evt.xferLoad) begin
                interruptStatus[7 - msq_regs_pkg::INT_XFER] <= 1'b0;
            end
            if (evt.opIn && !opInPrev && evt.selChOption) begin
                interruptStatus[7 - msq_regs_pkg::INT_SELCH] <= 1'b1;
            end
            interruptStatus[7 - msq_regs_pkg::INT_WRAP] <= cntLoad ? 1'b0
                : (counterCarry | &cycleCounterReg);
            if (evt.indexAlert) begin
                interruptStatus[7 - msq_regs_pkg::INT_INDEX] <= 1'b1;
            end else if (uop.clearIndex) begin
                interruptStatus[7 - msq_regs_pkg::INT_INDEX] <= 1'b0;
            end
            interruptStatus[7 - msq_regs_pkg::INT_CHAN] <= evt.opIn
                ? ((evt.addressOut && !evt.selectOut) || evt.truncation)
                : evt.selectionLatch;
            interruptStatus[7 - msq_regs_pkg::INT_RESP] <=
                evt.tagAccepted | evt.okEnd | evt.errEnd;
            interruptStatus[7 - msq_regs_pkg::INT_CHK2] <= checkTwoLatch;
        end
    end

    a_mask_branch: assert property (@(posedge clk) disable iff (!rst_n)
        (uop.dSel == msq_regs_pkg::D_MASK)
        |=> maskedIntBranch == |(interruptStatus & $past(uop.dBus)))
        else $error("masked branch mismatch");
    a_counter_incr: assert property (@(posedge clk) disable iff (!rst_n)
        (!cntLoad) |=> cycleCounterReg == $past(cycleCounterReg) + 8'h01)
        else $error("counter did not increment");
    a_counter_load: assert property (@(posedge clk) disable iff (!rst_n)
        (uop.dSel == msq_regs_pkg::D_CNT)
        |=> !counterCarry && cycleCounterReg == $past(uop.dBus))
        else $error("counter load wrong");
    a_resp_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (evt.tagAccepted | evt.okEnd | evt.errEnd) |=> interruptStatus[1])
        else $error("response bit not set");
    a_index_set: assert property (@(posedge clk) disable iff (!rst_n)
        evt.indexAlert |=> interruptStatus[3])
        else $error("index bit not set");
    a_return_save: assert property (@(posedge clk) disable iff (!rst_n)
        uop.saveReturn |=> returnAddress == $past(curAddr) + 13'h0001)
        else $error("return address wrong");
    a_branch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> branchHold == $past(branchSourceBus))
        else $error("branch hold stale");
    a_chk_view: assert property (@(posedge clk) disable iff (!rst_n)
        checkMuxControl[3] && uop.aSel == msq_regs_pkg::A_CHK |-> aBus == channelCheck)
        else $error("check view wrong");
endmodule
`default_nettype wire

/* verification/microop_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
module microop_source_model (
    input wire logic clk,
    output var msq_regs_pkg::uop_type uop,
    output var msq_regs_pkg::events_type evt
);
    initial begin
        uop = '0;
        evt = '0;
    end
    // launched at the falling edge so register time always sees settled controls
    task automatic go(input msq_regs_pkg::uop_type u, input msq_regs_pkg::events_type e);
        @(negedge clk);
        uop = u;
        evt = e;
        #1;
    endtask
endmodule
`default_nettype wire

/* verification/microsequencer_register_set_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module microsequencer_register_set_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [12:0] curAddr = 13'h0000;
    logic [7:0] channelCheck = 8'h5A;
    logic [46:0] faultSet = '0;
    logic [46:0] fs = '0;
    msq_regs_pkg::uop_type uop, u;
    msq_regs_pkg::events_type evt, e;
    logic [7:0] aBus, bBus, branchSourceBus, branchHold, interruptStatus;
    logic [31:0] tBusOut;
    logic [12:0] returnAddress;
    logic maskedIntBranch, counterWrapBranch, returnJumpTaken, enableCheck;
    logic [1:0] errorCapturePages;
    int mismatches = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    microop_source_model src (.clk(clk), .uop(uop), .evt(evt));
    microsequencer_register_set dut (.clk(clk), .rst_n(rst_n), .uop(uop), .evt(evt),
        .curAddr(curAddr), .channelCheck(channelCheck), .faultSet(faultSet), .aBus(aBus),
        .bBus(bBus), .tBusOut(tBusOut), .branchSourceBus(branchSourceBus),
        .branchHold(branchHold), .maskedIntBranch(maskedIntBranch),
        .counterWrapBranch(counterWrapBranch), .returnAddress(returnAddress),
        .returnJumpTaken(returnJumpTaken), .enableCheck(enableCheck),
        .errorCapturePages(errorCapturePages), .interruptStatus(interruptStatus));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // one microinstruction; fault pulses last exactly that cycle
    task automatic run();
        src.go(u, e);
        faultSet = fs;
        fs = '0;
        u = '0;
        e = '0;
    endtask
    task automatic wd(input logic [4:0] d, input logic [7:0] v);
        u.dSel = d;
        u.dBus = v;
        run();
    endtask
    task automatic ra(input logic [3:0] a, input logic [7:0] x);
        u.aSel = a;
        run();
        check(aBus, x);
    endtask
    task automatic tx(input logic [3:0] t, input logic [31:0] v);
        u.tSel = t;
        u.tBusIn = v;
        run();
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
    initial begin
        u = '0;
        e = '0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        ra(msq_regs_pkg::A_PAGE, 8'h00);
        check(interruptStatus, 8'h00);
        e = '{chByteDone: 1'b1, xferDecToZero: 1'b1, indexAlert: 1'b1, tagAccepted: 1'b1,
            checkTwoSet: 1'b1, default: 1'b0};
        run();
        e = '{okEnd: 1'b1, default: 1'b0};
        run();
        // bit 7 may lag its latch by one register time
        check(interruptStatus[7:1], 7'h65);
        e = '{errEnd: 1'b1, default: 1'b0};
        run();
        check(interruptStatus, 8'hCB);
        run();
        check(interruptStatus, 8'hCB);
        run();
        check(interruptStatus, 8'hC9);
        e = '{chCounterLoad: 1'b1, xferLoad: 1'b1, default: 1'b0};
        u.clearIndex = 1'b1;
        u.clearChecks = 1'b1;
        run();
        run();
        run();
        check(interruptStatus, 8'h00);
        e = '{selectionLatch: 1'b1, default: 1'b0};
        run();
        run();
        check(interruptStatus[2], 1'b1);
        e = '{opIn: 1'b1, selChOption: 1'b1, addressOut: 1'b1, default: 1'b0};
        run();
        e = '{opIn: 1'b1, addressOut: 1'b1, selectOut: 1'b1, selectionLatch: 1'b1, default: 1'b0};
        run();
        check(interruptStatus[2], 1'b1);
        check(interruptStatus[5], 1'b1);
        e = '{opIn: 1'b1, truncation: 1'b1, default: 1'b0};
        run();
        check(interruptStatus[2], 1'b0);
        run();
        check(interruptStatus[2], 1'b1);
        wd(msq_regs_pkg::D_CNT, 8'hFD);
        ra(msq_regs_pkg::A_CNT, 8'hFD);
        ra(msq_regs_pkg::A_CNT, 8'hFE);
        ra(msq_regs_pkg::A_CNT, 8'hFF);
        check(counterWrapBranch, 1'b0);
        ra(msq_regs_pkg::A_CNT, 8'h00);
        check(counterWrapBranch, 1'b1);
        wd(msq_regs_pkg::D_MASK, 8'h10);
        check(interruptStatus[4], 1'b1);
        wd(msq_regs_pkg::D_MASK, 8'h08);
        check(maskedIntBranch, 1'b1);
        wd(msq_regs_pkg::D_CNT, 8'h00);
        check(maskedIntBranch, 1'b0);
        run();
        check(counterWrapBranch, 1'b0);
        check(interruptStatus[4], 1'b0);
        wd(msq_regs_pkg::D_PAGE, 8'h30);
        wd(msq_regs_pkg::D_SCR0 + 5'h01, 8'hAA);
        ra(msq_regs_pkg::A_SCR1, 8'hAA);
        u.aSel = msq_regs_pkg::A_SCR1;
        wd(msq_regs_pkg::D_PAGE, 8'h40);
        check(aBus, 8'hAA);
        ra(msq_regs_pkg::A_SCR1, 8'h00);
        wd(msq_regs_pkg::D_PAGE, 8'h30);
        tx(msq_regs_pkg::T_SCR_FROM_T, 32'h11223344);
        tx(msq_regs_pkg::T_SCR_TO_T, 32'h00000000);
        check(tBusOut, 32'h11AA0044);
        tx(msq_regs_pkg::T_GEN_FROM_SCR, 32'h00000000);
        u.bSel = msq_regs_pkg::A_GEN1;
        tx(msq_regs_pkg::T_GEN_TO_T, 32'h00000000);
        check(tBusOut, 32'h11AA0044);
        check(bBus, 8'hAA);
        wd(msq_regs_pkg::D_GEN0, 8'h77);
        wd(msq_regs_pkg::D_PAGE, 8'h50);
        tx(msq_regs_pkg::T_SCR_FROM_GEN, 32'h00000000);
        tx(msq_regs_pkg::T_SCR_TO_T, 32'h00000000);
        check(tBusOut, 32'h77AA0044);
        for (int i = 0; i < 4; i++) begin
            wd(msq_regs_pkg::D_GEN4 + 5'(i), 8'hC0 + 8'(i));
            ra(msq_regs_pkg::A_GEN4 + 4'(i), 8'hC0 + 8'(i));
        end
        wd(msq_regs_pkg::D_PAGE, 8'h06);
        run();
        check(branchSourceBus, 8'hC3);
        wd(msq_regs_pkg::D_PAGE, 8'h00);
        check(branchHold, 8'hC3);
        run();
        check(branchSourceBus, 8'hC0);
        wd(msq_regs_pkg::D_MCM, 8'h08);
        ra(msq_regs_pkg::A_CHK, 8'h5A);
        e.bufCorrectable = 1'b1;
        wd(msq_regs_pkg::D_MCM, 8'hB3);
        ra(msq_regs_pkg::A_CHK, 8'h40);
        check(enableCheck, 1'b1);
        check(errorCapturePages, 2'h3);
        e.bufUncorrectable = 1'b1;
        wd(msq_regs_pkg::D_MCM, 8'h01);
        ra(msq_regs_pkg::A_CHK, 8'h04);
        fs[46] = 1'b1;
        wd(msq_regs_pkg::D_MCM, 8'h05);
        ra(msq_regs_pkg::A_CHK, 8'h02);
        curAddr = 13'h0123;
        u.saveReturn = 1'b1;
        run();
        u.returnJump = 1'b1;
        run();
        check(returnAddress, 13'h0124);
        check(returnJumpTaken, 1'b1);
        tx(msq_regs_pkg::T_SCR_FROM_RET, 32'h00000000);
        tx(msq_regs_pkg::T_SCR_TO_T, 32'h00000000);
        check(tBusOut[12:0], 13'h0124);
        tx(msq_regs_pkg::T_PAGE_FROM_T, 32'h00000050);
        ra(msq_regs_pkg::A_PAGE, 8'h50);
        tx(msq_regs_pkg::T_SCRHI_FROM_T, 32'h0000BEEF);
        tx(msq_regs_pkg::T_RET_FROM_SCR, 32'h00000000);
        tx(msq_regs_pkg::T_SCR_TO_T, 32'h00000000);
        check(tBusOut, 32'h77AABEEF);
        check(returnAddress, 13'h1EEF);
        wd(msq_regs_pkg::D_SCR0 + 5'h03, 8'h9C);
        ra(msq_regs_pkg::A_SCR3, 8'h9C);
        tx(msq_regs_pkg::T_CNT_FROM_T, 32'h000000F0);
        ra(msq_regs_pkg::A_CNT, 8'hF0);
        tx(msq_regs_pkg::T_GEN_FROM_T, 32'h01020304);
        ra(msq_regs_pkg::A_GEN3, 8'h04);
        tx(msq_regs_pkg::T_GENLO_FROM_T, 32'h0000A5B6);
        ra(msq_regs_pkg::A_GEN2, 8'hA5);
        ra(msq_regs_pkg::A_GEN0, 8'h01);
        summarize();
    end
endmodule
`default_nettype wire
